// ---- hdl/fdccfg_bank.v ----
// Configuration bank of the floppy controller logical device.
// Assumes a plain register port with read data one cycle after the strobe.
`timescale 1ns/1ps
`include "fdccfg_map.vh"
// Contract
// - Command byte bit 6 picks FM or MFM
// - Floated pin bits read as one
// - No media sense, no upper rate output
// - Configuration resets to 24h
// - Bit 7 selects two direct or four encoded
// - Bit 6 picks AT or enhanced drive type
// - Bit 5 sets density output polarity
// - Bit 4 selects 48 or 24 MHz clock
// - Bit 3 forces write protection
// - Bit 2 selects drive interface mode
// - Bit 0 floats outputs when inactive
// - Drive identification resets zero, feeds type
// - Drive one uses bits 3-2, else 1-0
// - Base address resets 03h and F2h, masked
// - Interrupt type resets 03h, bit 1 writable
// - Second DMA reads 04h, DMA select 02h
// - Interrupt number 06h, activation 00h
module fdccfg_bank (
    // Clock and reset
    input  wire       clock,
    input  wire       resetn,
    // Register port
    input  wire [7:0] regAddr,
    input  wire [7:0] regWdata,
    input  wire       regWrite,
    input  wire       regRead,
    output reg  [7:0] regRdata,
    // Core command and drive interface
    input  wire [7:0] cmdByte,
    input  wire       cmdFirst,
    input  wire [1:0] driveNum,
    input  wire [3:0] motorReq,
    input  wire       highRate,
    input  wire       writeProtectIn,
    input  wire [1:0] typeCoreLow,
    input  wire [1:0] typeCoreHigh,
    input  wire [7:0] pinStatusIn,
    // Derived settings and pins
    output reg        mfmCoding,
    output wire [7:0] driveTypeValue,
    output wire [7:0] pinStatusRead,
    output wire [1:0] driveSelectLines,
    output wire [1:0] motorOnLines,
    output wire       densitySelectOut,
    output wire       clock48Sel,
    output wire       rate2mEnable,
    output wire       writeProtectEff,
    output wire       atDriveMode,
    output wire       outputsFloat,
    output wire       outputEnableN,
    output wire       upperRateSelectOut,
    output wire       mediaSenseEnable
);
    reg  [7:0] activate_ff;
    reg  [7:0] baseHi_ff;
    reg  [7:0] baseLo_ff;
    reg  [7:0] irqNum_ff;
    reg  [7:0] irqType_ff;
    reg  [7:0] dmaSel_ff;
    reg  [7:0] config_ff;
    reg  [7:0] driveId_ff;
    reg  [7:0] nxt_rdata;
    wire [1:0] dsel;
    wire [1:0] mtr;

    function [7:0] merge;
        input [7:0] old;
        input [7:0] din;
        input [7:0] msk;
        begin
            merge = (old & ~msk) | (din & msk);
        end
    endfunction

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            activate_ff <= `FDCCFG_RST_ACTIVATE;
            baseHi_ff   <= `FDCCFG_RST_BASE_HI;
            baseLo_ff   <= `FDCCFG_RST_BASE_LO;
            irqNum_ff   <= `FDCCFG_RST_IRQ_NUM;
            irqType_ff  <= `FDCCFG_RST_IRQ_TYPE;
            dmaSel_ff   <= `FDCCFG_RST_DMA_SEL;
            config_ff   <= `FDCCFG_RST_CONFIG;
            driveId_ff  <= `FDCCFG_RST_DRIVE_IDENTIFICATION;
        end else if (regWrite) begin
            case (regAddr)
                `FDCCFG_IDX_ACTIVATE: activate_ff <= regWdata;
                `FDCCFG_IDX_BASE_HI: baseHi_ff <=
                    merge(baseHi_ff, regWdata, `FDCCFG_MSK_BASE_HI);
                `FDCCFG_IDX_BASE_LO: baseLo_ff <=
                    merge(baseLo_ff, regWdata, `FDCCFG_MSK_BASE_LO);
                `FDCCFG_IDX_IRQ_NUM: irqNum_ff <= regWdata;
                `FDCCFG_IDX_IRQ_TYPE: irqType_ff <=
                    merge(irqType_ff, regWdata, `FDCCFG_MSK_IRQ_TYPE);
                `FDCCFG_IDX_DMA_SEL: dmaSel_ff <= regWdata;
                `FDCCFG_IDX_CONFIG: config_ff <=
                    merge(config_ff, regWdata, `FDCCFG_MSK_CONFIG);
                `FDCCFG_IDX_DRIVE_IDENTIFICATION: driveId_ff <=
                    merge(driveId_ff, regWdata, `FDCCFG_MSK_DRIVE_IDENTIFICATION);
                default: ;
            endcase
        end
    end

    // Coding is caught from the first command byte of a transfer
    always @(posedge clock or negedge resetn) begin
        if (!resetn)
            mfmCoding <= 1'b0;
        else if (cmdFirst)
            mfmCoding <= cmdByte[`FDCCFG_BIT_CODING];
    end

    always @* begin
        nxt_rdata = 8'h00;
        case (regAddr)
            `FDCCFG_IDX_ACTIVATE: nxt_rdata = activate_ff;
            `FDCCFG_IDX_BASE_HI:  nxt_rdata = baseHi_ff;
            `FDCCFG_IDX_BASE_LO:  nxt_rdata = baseLo_ff;
            `FDCCFG_IDX_IRQ_NUM:  nxt_rdata = irqNum_ff;
            `FDCCFG_IDX_IRQ_TYPE: nxt_rdata = irqType_ff;
            `FDCCFG_IDX_DMA_SEL:  nxt_rdata = dmaSel_ff;
            `FDCCFG_IDX_DMA2_RPT: nxt_rdata = `FDCCFG_VAL_DMA2_RPT;
            `FDCCFG_IDX_CONFIG:   nxt_rdata = config_ff;
            `FDCCFG_IDX_DRIVE_IDENTIFICATION: nxt_rdata = driveId_ff;
            `FDCCFG_IDX_STATUS:   nxt_rdata = pinStatusRead;
            default:              nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn)
            regRdata <= 8'h00;
        else if (regRead)
            regRdata <= nxt_rdata;
        else
            regRdata <= 8'h00;
    end

    assign outputsFloat = config_ff[`FDCCFG_BIT_FLOAT_EN] &
                          ~activate_ff[`FDCCFG_BIT_ACTIVE];
    assign outputEnableN = outputsFloat;
    assign pinStatusRead = outputsFloat ? 8'hFF : pinStatusIn;

    fdccfg_drive_sel uDriveSel (
        .fourDrive        (config_ff[`FDCCFG_BIT_FOUR_DRV]),
        .driveNum         (driveNum),
        .motorReq         (motorReq),
        .driveSelectLines (dsel),
        .motorOnLines     (mtr)
    );
    assign driveSelectLines = dsel;
    assign motorOnLines     = mtr;

    fdccfg_drive_type uDriveType (
        .enhanced (config_ff[`FDCCFG_BIT_DTYPE_MODE]),
        .driveId  (driveId_ff[3:0]),
        .driveOne (driveNum == 2'd1),
        .coreLow  (typeCoreLow),
        .coreHigh (typeCoreHigh),
        .value    (driveTypeValue)
    );

    // Density level is raw high-rate flag, flipped for active-low polarity
    assign densitySelectOut = ~(highRate ^
                                config_ff[`FDCCFG_BIT_DENS_POL]);
    assign clock48Sel      = config_ff[`FDCCFG_BIT_RATE2M];
    assign rate2mEnable    = config_ff[`FDCCFG_BIT_RATE2M];
    assign writeProtectEff = writeProtectIn |
                             config_ff[`FDCCFG_BIT_WPROT];
    assign atDriveMode     = config_ff[`FDCCFG_BIT_DRV_MODE];
    assign upperRateSelectOut = 1'b0;
    assign mediaSenseEnable   = 1'b0;
endmodule

// ---- hdl/fdccfg_drive_sel.v ----
// Drive select and motor encoding for two direct or four decoded drives.
// Assumes a one-hot motor request and a 2-bit drive number from the core.
`timescale 1ns/1ps
module fdccfg_drive_sel (
    // Mode
    input  wire       fourDrive,
    // Core requests
    input  wire [1:0] driveNum,
    input  wire [3:0] motorReq,
    // Lines
    output reg  [1:0] driveSelectLines,
    output reg  [1:0] motorOnLines
);
    always @* begin
        if (fourDrive) begin
            // Encoded pair for an external decoder
            driveSelectLines = driveNum;
            motorOnLines     = {1'b0, motorReq[driveNum]};
        end else begin
            driveSelectLines = {driveNum == 2'd1, driveNum == 2'd0};
            motorOnLines     = motorReq[1:0];
        end
    end
endmodule

// ---- hdl/fdccfg_drive_type.v ----
// Drive type register read value built from mode and drive identification.
// Assumes the core gives the low two bits and the accessed drive.
`timescale 1ns/1ps
`include "fdccfg_map.vh"
module fdccfg_drive_type (
    // Mode
    input  wire       enhanced,
    // Inputs
    input  wire [3:0] driveId,
    input  wire       driveOne,
    input  wire [1:0] coreLow,
    input  wire [1:0] coreHigh,
    // Result
    output reg  [7:0] value
);
    always @* begin
        if (!enhanced)
            value = {`FDCCFG_DTYPE_AT_HIGH, coreLow};
        else if (driveOne)
            value = {coreHigh, driveId[3:2], 2'b00, coreLow};
        else
            value = {coreHigh, driveId[1:0], 2'b00, coreLow};
    end
endmodule

// ---- shared/fdccfg_map.vh ----
// Register indices, field positions and reset values of the floppy
// controller configuration bank.
// Assumes inclusion by bare name from the design files.
`ifndef FDCCFG_MAP_VH
`define FDCCFG_MAP_VH

`define FDCCFG_IDX_ACTIVATE   8'h30
`define FDCCFG_IDX_BASE_HI    8'h60
`define FDCCFG_IDX_BASE_LO    8'h61
`define FDCCFG_IDX_IRQ_NUM    8'h70
`define FDCCFG_IDX_IRQ_TYPE   8'h71
`define FDCCFG_IDX_DMA_SEL    8'h74
`define FDCCFG_IDX_DMA2_RPT   8'h75
`define FDCCFG_IDX_CONFIG     8'hF0
`define FDCCFG_IDX_DRIVE_IDENTIFICATION   8'hF1
`define FDCCFG_IDX_STATUS     8'hF2

`define FDCCFG_RST_ACTIVATE   8'h00
`define FDCCFG_RST_BASE_HI    8'h03
`define FDCCFG_RST_BASE_LO    8'hF2
`define FDCCFG_RST_IRQ_NUM    8'h06
`define FDCCFG_RST_IRQ_TYPE   8'h03
`define FDCCFG_RST_DMA_SEL    8'h02
`define FDCCFG_VAL_DMA2_RPT   8'h04
`define FDCCFG_RST_CONFIG     8'h24
`define FDCCFG_RST_DRIVE_IDENTIFICATION   8'h00

`define FDCCFG_MSK_BASE_HI    8'h07
`define FDCCFG_MSK_BASE_LO    8'hFA
`define FDCCFG_MSK_IRQ_TYPE   8'h02
`define FDCCFG_MSK_CONFIG     8'hFD
`define FDCCFG_MSK_DRIVE_IDENTIFICATION   8'h0F

`define FDCCFG_BIT_FOUR_DRV   7
`define FDCCFG_BIT_DTYPE_MODE 6
`define FDCCFG_BIT_DENS_POL   5
`define FDCCFG_BIT_RATE2M     4
`define FDCCFG_BIT_WPROT      3
`define FDCCFG_BIT_DRV_MODE   2
`define FDCCFG_BIT_FLOAT_EN   0
`define FDCCFG_BIT_ACTIVE     0
`define FDCCFG_BIT_CODING     6
`define FDCCFG_DTYPE_AT_HIGH  6'h3F

`endif

// ---- verification/fdccfg_drive_model.sv ----
// Drive side model: write-protect level and pin state bits.
// Assumes the bench clock; lines move right after each rising edge.
`timescale 1ns/1ps
module fdccfg_drive_model (
    // Clock
    input  wire logic clock,
    // Drive lines
    output logic       writeProtectIn,
    output logic [7:0] pinStatusIn
);
    initial begin
        writeProtectIn = 1'b0;
        pinStatusIn = 8'h5a;
    end
    always @(posedge clock) begin
        writeProtectIn <= pinStatusIn[0] ^ pinStatusIn[3];
        pinStatusIn <= {pinStatusIn[6:0], pinStatusIn[7] ^ pinStatusIn[5]};
    end
endmodule

// ---- verification/fdccfg_monitor.sv ----
// Checker on the configuration bank ports.
// Assumes bank ports keep their declared names; bound below.
`timescale 1ns/1ps
module fdccfg_monitor (
    // Clock and reset
    input wire logic       clock,
    input wire logic       resetn,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdata,
    // Core side
    input wire logic [7:0] cmdByte,
    input wire logic       cmdFirst,
    input wire logic       highRate,
    input wire logic       writeProtectIn,
    // Derived settings and pins
    input wire logic       mfmCoding,
    input wire logic [7:0] pinStatusRead,
    input wire logic       densitySelectOut,
    input wire logic       clock48Sel,
    input wire logic       rate2mEnable,
    input wire logic       writeProtectEff,
    input wire logic       atDriveMode,
    input wire logic       outputsFloat,
    input wire logic       outputEnableN,
    input wire logic       upperRateSelectOut,
    input wire logic       mediaSenseEnable
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_cfgWr; regWrite && regAddr == 8'hf0; endsequence
    sequence s_cfgRd; regRead && regAddr == 8'hf0; endsequence
    sequence s_idRd; regRead && regAddr == 8'hf1; endsequence
    property p_coding; cmdFirst |=> mfmCoding == $past(cmdByte[6]); endproperty
    property p_float; outputsFloat |-> pinStatusRead == 8'hff; endproperty
    property p_none; !upperRateSelectOut && !mediaSenseEnable; endproperty
    property p_dens;
        s_cfgWr |=> densitySelectOut == (highRate ~^ $past(regWdata[5]));
    endproperty
    property p_rate;
        s_cfgWr |=> clock48Sel == $past(regWdata[4]) &&
                    rate2mEnable == $past(regWdata[4]);
    endproperty
    property p_wake;
        regWrite && regAddr == 8'h30 && regWdata[0] |=> !outputsFloat;
    endproperty
    property p_rsvdCfg; s_cfgRd |=> regRdata[1] == 1'b0; endproperty
    property p_rsvdId; s_idRd |=> regRdata[7:4] == 4'h0; endproperty
    property p_wp; writeProtectIn |-> writeProtectEff; endproperty
    property p_mode; s_cfgWr |=> atDriveMode == $past(regWdata[2]); endproperty
    property p_oe; outputEnableN == outputsFloat; endproperty
    property p_dma2; regRead && regAddr == 8'h75 |=> regRdata == 8'h04;
    endproperty
    a_coding: assert property (p_coding) else $error("coding");
    a_float: assert property (p_float) else $error("float");
    a_none: assert property (p_none) else $error("none");
    a_dens: assert property (p_dens) else $error("density");
    a_rate: assert property (p_rate) else $error("rate");
    a_wp: assert property (p_wp) else $error("protect");
    a_mode: assert property (p_mode) else $error("mode");
    a_oe: assert property (p_oe) else $error("enable");
    a_dma2: assert property (p_dma2) else $error("dma2");
    a_wake: assert property (p_wake) else $error("wake");
    a_rsvdCfg: assert property (p_rsvdCfg) else $error("rsvd cfg");
    a_rsvdId: assert property (p_rsvdId) else $error("rsvd id");
endmodule
bind fdccfg_bank fdccfg_monitor i_fdccfg_monitor (.*);

// ---- verification/testbench.sv ----
// Self-checking bench for the configuration bank.
// Assumes the drive model and the bound checker.
`timescale 1ns/1ps
module testbench;
    logic       clock, resetn, regWrite, regRead, cmdFirst, highRate;
    logic       writeProtectIn, mfmCoding, densitySelectOut, clock48Sel;
    logic       rate2mEnable, writeProtectEff, atDriveMode, outputsFloat;
    logic       outputEnableN, upperRateSelectOut, mediaSenseEnable;
    logic [7:0] regAddr, regWdata, regRdata, cmdByte, pinStatusIn;
    logic [7:0] driveTypeValue, pinStatusRead, cfg, act;
    logic [3:0] motorReq, driveId;
    logic [1:0] driveNum, typeCoreLow, typeCoreHigh;
    logic [1:0] driveSelectLines, motorOnLines;
    logic [31:0] seed = 32'h1b0f_790e;
    int         n_fail = 0;
    int         comparisons = 0;
    logic [7:0] idx [10] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74,
                             8'h75, 8'hf0, 8'hf1, 8'h55};
    logic [7:0] rst [10] = '{8'h00, 8'h03, 8'hf2, 8'h06, 8'h03, 8'h02,
                             8'h04, 8'h24, 8'h00, 8'h00};
    logic [7:0] msk [10] = '{8'hff, 8'h07, 8'hfa, 8'hff, 8'h02, 8'hff,
                             8'h00, 8'hfd, 8'h0f, 8'h00};

    fdccfg_bank i_fdccfg_bank (.*);
    fdccfg_drive_model i_fdccfg_drive_model (.*);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] typeExp();
        logic [1:0] id;
        id = (driveNum == 2'd1) ? driveId[3:2] : driveId[1:0];
        return cfg[6] ? {typeCoreHigh, id, 2'b00, typeCoreLow}
                      : {6'h3f, typeCoreLow};
    endfunction

    // Pin state one edge back, undoing one step of the drive model
    function automatic logic [7:0] prevPins(logic [7:0] now);
        return {now[0] ^ now[6], now[7:1]};
    endfunction

    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, output logic [7:0] q);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        #1 q = regRdata;
    endtask

    task end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        n_fail++;
        end_sim;
    end

    initial begin
        logic [7:0] q, d;
        logic       fl;
        {resetn, regWrite, regRead, cmdFirst, highRate} = '0;
        {regAddr, regWdata, cmdByte, motorReq, driveNum} = '0;
        {typeCoreLow, typeCoreHigh} = '0;
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd(idx[i], q);
            chk("reset", rst[i], q);
        end
        for (int i = 0; i < 10; i++) begin
            d = 8'(rnd());
            wr(idx[i], d);
            rd(idx[i], q);
            chk("access", (rst[i] & ~msk[i]) | (d & msk[i]),
                q);
        end
        for (int i = 0; i < 200; i++) begin
            cfg = 8'(rnd());
            act = 8'(rnd());
            d = (i == 0) ? 8'h0a : 8'(rnd());
            driveId = d[3:0];
            wr(8'hf0, cfg);
            wr(8'hf1, d);
            wr(8'h30, act);
            fl = cfg[0] & ~act[0];
            @(posedge clock);
            {highRate, motorReq, typeCoreLow, typeCoreHigh, driveNum}
                <= 11'(rnd()) & {9'h1ff, cfg[7], 1'b1};
            cmdFirst <= 1'b1;
            cmdByte <= 8'(rnd());
            #1 chk("drive type", typeExp(),
                driveTypeValue);
            chk("select", cfg[7] ? driveNum : {driveNum[0], ~driveNum[0]},
                driveSelectLines);
            chk("motor", cfg[7] ? {1'b0, motorReq[driveNum]} : motorReq[1:0],
                motorOnLines);
            chk("settings", {highRate ~^ cfg[5], cfg[4], cfg[4],
                writeProtectIn | cfg[3], cfg[2], fl}, {densitySelectOut,
                clock48Sel, rate2mEnable, writeProtectEff, atDriveMode,
                outputsFloat});
            chk("pins", fl ? 8'hff : pinStatusIn, pinStatusRead);
            chk("pin enable", {5'h00, fl, 2'b00}, {5'h00, outputEnableN,
                upperRateSelectOut, mediaSenseEnable});
            @(posedge clock);
            cmdFirst <= 1'b0;
            #1 chk("coding", {7'h0, cmdByte[6]}, {7'h0, mfmCoding});
            rd(8'hf2, q);
            chk("status", fl ? 8'hff : prevPins(pinStatusIn), q);
        end
        // Reset again in mid-run, after every register has been written
        @(posedge clock);
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        chk("coding reset", 8'h00, {7'h0, mfmCoding});
        for (int i = 0; i < 10; i++) begin
            rd(idx[i], q);
            chk("reset again", rst[i], q);
        end
        end_sim;
    end
endmodule
